// ### src/snc_pkg.sv
/*
  shared constants and types for the serial nand command block:
  opcodes, feature addresses, write masks, field positions and timings.
  assumes a 50 MHz system clock sampling the serial pins.
*/
package snc_pkg;
  // opcodes
  localparam logic [7:0] OP_WR_ENABLE = 8'h06;
  localparam logic [7:0] OP_WR_DISABLE = 8'h04;
  localparam logic [7:0] OP_GET_FEAT = 8'h0F;
  localparam logic [7:0] OP_SET_FEAT = 8'h1F;
  localparam logic [7:0] OP_PAGE_READ = 8'h13;
  localparam logic [7:0] OP_RD_CACHE = 8'h03;
  localparam logic [7:0] OP_RD_FAST = 8'h0B;
  localparam logic [7:0] OP_RD_X2 = 8'h3B;
  localparam logic [7:0] OP_RD_X4 = 8'h6B;
  localparam logic [7:0] OP_RD_DUAL_IO = 8'hBB;
  localparam logic [7:0] OP_RD_QUAD_IO = 8'hEB;
  localparam logic [7:0] OP_READ_ID = 8'h9F;
  localparam logic [7:0] OP_PROG_EXEC = 8'h10;
  localparam logic [7:0] OP_BLOCK_ERASE = 8'hD8;
  localparam logic [7:0] OP_RESET = 8'hFF;
  // feature register addresses
  localparam logic [7:0] FA_PROT = 8'hA0;
  localparam logic [7:0] FA_CFG = 8'hB0;
  localparam logic [7:0] FA_STAT = 8'hC0;
  localparam logic [7:0] FA_DRV = 8'hD0;
  // writable bits, reserved bits always stored as zero
  localparam logic [7:0] WM_PROT = 8'hBE;
  localparam logic [7:0] WM_CFG = 8'hD1;
  localparam logic [7:0] WM_DRV = 8'h60;
  localparam logic [7:0] DRV_RESET = 8'h00;
  localparam logic [7:0] PROT_RESET = 8'h00;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam int GUARD_BIT = 7;
  localparam int QE_BIT = 0;
  localparam int OTP_PROTECT_BIT = 7;
  // lane widths and byte framing
  localparam logic [2:0] W1 = 3'h1;
  localparam logic [2:0] W2 = 3'h2;
  localparam logic [2:0] W4 = 3'h4;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [11:0] COL_LAST = 12'h87F;
  localparam logic [7:0] OOB_BYTE = 8'hFF;
  // array operation codes
  localparam logic [1:0] AOP_READ = 2'h0;
  localparam logic [1:0] AOP_PROG = 2'h1;
  localparam logic [1:0] AOP_ERASE = 2'h2;
  // timing
  localparam int CLK_NS = 20;
  localparam int T_RD_NS = 80000;
  localparam int T_PROG_NS = 600000;
  localparam int T_ERS_NS = 4000000;
  localparam int RD_CYCLES = T_RD_NS / CLK_NS;
  typedef enum logic [1:0] {PH_CMD, PH_ADDR, PH_OUT, PH_IGNORE} snc_phase_t;
  typedef enum logic [1:0] {SRC_FEAT, SRC_ID, SRC_CACHE} snc_src_t;
  typedef struct packed {
    logic rsv;
    logic [2:0] ecc;
    logic p_fail;
    logic e_fail;
    logic write_enable_latch;
    logic operation_in_progress;
  } snc_status_t;
endpackage

// ### src/snc_top.sv
/*
  serial nand command interpreter: write latch, feature registers,
  page read to cache, all read-from-cache forms and the id read.
  assumes sclk, cs_n and sio come from a host on another clock and are
  synchronised here; the cache is filled by the array through a port.
*/
`timescale 1ns/1ps
module snc_top #(
  parameter logic [7:0] MFR_ID = 8'h5A, // arbitrary value
  parameter logic [7:0] DEV_ID0 = 8'h3C, // arbitrary value
  parameter logic [7:0] DEV_ID1 = 8'h11, // arbitrary value
  parameter int PROG_CYCLES = snc_pkg::T_PROG_NS / snc_pkg::CLK_NS,
  parameter int ERASE_CYCLES = snc_pkg::T_ERS_NS / snc_pkg::CLK_NS
)(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] sio_in,
  output logic [3:0] sio_out,
  output logic [3:0] sio_oe,
  input wire logic otp_protect_nv,
  input wire logic cache_wr_en,
  input wire logic [11:0] cache_wr_addr,
  input wire logic [7:0] cache_wr_data,
  input wire logic arr_fail,
  input wire logic [2:0] arr_ecc,
  output logic arr_start,
  output logic [1:0] arr_op,
  output logic [23:0] arr_row
);
  logic [2:0] sclk_s_ff; // [0] feeds only [1]
  logic [1:0] cs_s_ff;
  logic [3:0] sio_s0_ff, sio_s1_ff;
  logic sclk_rise, sclk_fall, cs_act;
  snc_pkg::snc_phase_t phase_ff, nxt_phase;
  snc_pkg::snc_src_t src_ff, nxt_src;
  logic [7:0] op_ff, byte_cnt_ff, nb, feat_addr_ff;
  logic [2:0] bit_cnt_ff, w_in, w_out;
  logic [7:0] in_sr_ff;
  logic [23:0] addr_sr_ff, nxt_addr;
  logic byte_done, ev_write_enable_cmd, ev_write_disable_cmd, ev_reset, ev_setf, ev_start, ev_out;
  logic [1:0] ev_op;
  logic [11:0] start_col, col_ff;
  logic [7:0] out_sr_ff, cur_byte, fetch;
  logic [2:0] out_cnt_ff;
  logic [7:0] prot_ff, cfg_ff, drv_ff;
  snc_pkg::snc_status_t stat_ff;
  logic [23:0] busy_cnt_ff;
  logic [1:0] busy_op_ff;
  logic busy_done, wp_n, qe;
  logic [7:0] cache_mem [0:2175]; // one page incl. spare area
  logic [3:0] sio_out_ff, sio_oe_ff;
  logic arr_start_ff;
  logic [1:0] arr_op_ff;
  logic [23:0] arr_row_ff;

  // feature read decode, used by output streaming only
  function automatic logic [7:0] feat_rd(input logic [7:0] a, input logic [7:0] p,
    input logic [7:0] c, input logic [7:0] s, input logic [7:0] d);
    case (a)
      snc_pkg::FA_PROT: feat_rd = p;
      snc_pkg::FA_CFG: feat_rd = c;
      snc_pkg::FA_STAT: feat_rd = s;
      snc_pkg::FA_DRV: feat_rd = d;
      default: feat_rd = 8'h00;
    endcase
  endfunction

  // output lane count by opcode
  function automatic logic [2:0] lanes_out(input logic [7:0] op);
    case (op)
      snc_pkg::OP_RD_X2, snc_pkg::OP_RD_DUAL_IO: lanes_out = snc_pkg::W2;
      snc_pkg::OP_RD_X4, snc_pkg::OP_RD_QUAD_IO: lanes_out = snc_pkg::W4;
      default: lanes_out = snc_pkg::W1;
    endcase
  endfunction

  // two-flop synchronisers; edges found from stages 1 and 2 only
  always_ff @(posedge clk)
  begin
    sclk_s_ff <= {sclk_s_ff[1:0], sclk};
    cs_s_ff <= {cs_s_ff[0], cs_n};
    sio_s0_ff <= sio_in;
    sio_s1_ff <= sio_s0_ff;
  end
  assign sclk_rise = sclk_s_ff[1] & ~sclk_s_ff[2];
  assign sclk_fall = ~sclk_s_ff[1] & sclk_s_ff[2];
  assign cs_act = ~cs_s_ff[1];
  assign qe = cfg_ff[snc_pkg::QE_BIT];
  // wp pin doubles as data line while quad is on, guard then off
  assign wp_n = sio_s1_ff[2] | qe;

  // input lane count: dual/quad io send address bytes wide too
  always_comb
  begin
    w_in = snc_pkg::W1;
    if (phase_ff == snc_pkg::PH_ADDR && op_ff == snc_pkg::OP_RD_DUAL_IO)
      w_in = snc_pkg::W2;
    else if (phase_ff == snc_pkg::PH_ADDR && op_ff == snc_pkg::OP_RD_QUAD_IO)
      w_in = snc_pkg::W4;
    w_out = lanes_out(op_ff);
    case (w_in)
      snc_pkg::W2: nb = {in_sr_ff[5:0], sio_s1_ff[1:0]};
      snc_pkg::W4: nb = {in_sr_ff[3:0], sio_s1_ff[3:0]};
      default: nb = {in_sr_ff[6:0], sio_s1_ff[0]};
    endcase
    byte_done = sclk_rise && cs_act &&
      (phase_ff == snc_pkg::PH_CMD || phase_ff == snc_pkg::PH_ADDR) &&
      (({1'b0, bit_cnt_ff} + {1'b0, w_in}) == snc_pkg::BYTE_BITS);
  end

  // command decode: one strobe per completed byte
  always_comb
  begin
    nxt_phase = phase_ff;
    nxt_src = src_ff;
    nxt_addr = {addr_sr_ff[15:0], nb};
    ev_write_enable_cmd = 1'b0;
    ev_write_disable_cmd = 1'b0;
    ev_reset = 1'b0;
    ev_setf = 1'b0;
    ev_start = 1'b0;
    ev_out = 1'b0;
    ev_op = snc_pkg::AOP_READ;
    start_col = 12'h000;
    if (byte_done && phase_ff == snc_pkg::PH_CMD)
    begin
      nxt_phase = snc_pkg::PH_ADDR;
      case (nb)
        snc_pkg::OP_WR_ENABLE:
        begin
          ev_write_enable_cmd = 1'b1;
          nxt_phase = snc_pkg::PH_IGNORE;
        end
        snc_pkg::OP_WR_DISABLE:
        begin
          ev_write_disable_cmd = 1'b1;
          nxt_phase = snc_pkg::PH_IGNORE;
        end
        snc_pkg::OP_RESET:
        begin
          ev_reset = 1'b1;
          nxt_phase = snc_pkg::PH_IGNORE;
        end
        snc_pkg::OP_READ_ID:
        begin
          ev_out = 1'b1;
          nxt_src = snc_pkg::SRC_ID;
          nxt_phase = snc_pkg::PH_OUT;
        end
        // quad forms dropped unless quad enable set
        snc_pkg::OP_RD_X4, snc_pkg::OP_RD_QUAD_IO:
          if (!qe)
            nxt_phase = snc_pkg::PH_IGNORE;
        snc_pkg::OP_GET_FEAT, snc_pkg::OP_SET_FEAT, snc_pkg::OP_RD_CACHE,
        snc_pkg::OP_RD_FAST, snc_pkg::OP_RD_X2, snc_pkg::OP_RD_DUAL_IO,
        snc_pkg::OP_PAGE_READ, snc_pkg::OP_PROG_EXEC, snc_pkg::OP_BLOCK_ERASE: ;
        default: nxt_phase = snc_pkg::PH_IGNORE; // unsupported opcode
      endcase
    end
    else if (byte_done)
    begin
      case (op_ff)
        snc_pkg::OP_GET_FEAT:
        begin
          ev_out = 1'b1;
          nxt_src = snc_pkg::SRC_FEAT;
          nxt_phase = snc_pkg::PH_OUT;
        end
        snc_pkg::OP_SET_FEAT:
          if (byte_cnt_ff == 8'h02)
          begin
            ev_setf = 1'b1;
            nxt_phase = snc_pkg::PH_IGNORE;
          end
        snc_pkg::OP_PAGE_READ, snc_pkg::OP_PROG_EXEC, snc_pkg::OP_BLOCK_ERASE:
          if (byte_cnt_ff == 8'h03)
          begin
            ev_start = ~stat_ff.operation_in_progress;
            ev_op = (op_ff == snc_pkg::OP_PAGE_READ) ? snc_pkg::AOP_READ :
              (op_ff == snc_pkg::OP_PROG_EXEC) ? snc_pkg::AOP_PROG : snc_pkg::AOP_ERASE;
            nxt_phase = snc_pkg::PH_IGNORE;
          end
        snc_pkg::OP_RD_CACHE:
          if (byte_cnt_ff == 8'h03)
          begin
            ev_out = 1'b1;
            start_col = nxt_addr[11:0];
          end
        snc_pkg::OP_RD_DUAL_IO, snc_pkg::OP_RD_QUAD_IO:
          if (byte_cnt_ff == 8'h03)
          begin
            ev_out = 1'b1;
            start_col = addr_sr_ff[11:0];
          end
        default:
          if (byte_cnt_ff == 8'h04)
          begin
            ev_out = 1'b1;
            start_col = addr_sr_ff[11:0];
          end
      endcase
      if (ev_out && op_ff != snc_pkg::OP_GET_FEAT)
      begin
        nxt_src = snc_pkg::SRC_CACHE;
        nxt_phase = snc_pkg::PH_OUT;
      end
    end
  end

  // framing state; deselect ends any command
  always_ff @(posedge clk)
  begin
    if (!reset_n || !cs_act)
    begin
      phase_ff <= snc_pkg::PH_CMD;
      src_ff <= snc_pkg::SRC_FEAT;
      bit_cnt_ff <= 3'h0;
      byte_cnt_ff <= 8'h00;
      in_sr_ff <= 8'h00;
      op_ff <= 8'h00;
      addr_sr_ff <= 24'h000000;
      feat_addr_ff <= 8'h00;
    end
    else if (sclk_rise && (phase_ff == snc_pkg::PH_CMD || phase_ff == snc_pkg::PH_ADDR))
    begin
      in_sr_ff <= nb;
      bit_cnt_ff <= byte_done ? 3'h0 : bit_cnt_ff + w_in;
      if (byte_done)
      begin
        byte_cnt_ff <= byte_cnt_ff + 8'h01;
        phase_ff <= nxt_phase;
        src_ff <= nxt_src;
        if (phase_ff == snc_pkg::PH_CMD)
          op_ff <= nb;
        else
          addr_sr_ff <= nxt_addr;
        if (phase_ff == snc_pkg::PH_ADDR && byte_cnt_ff == 8'h01)
          feat_addr_ff <= nb;
      end
    end
  end

  // next output byte: live feature, id or cache
  always_comb
  begin
    case (src_ff)
      snc_pkg::SRC_FEAT: fetch = feat_rd(feat_addr_ff, prot_ff, cfg_ff, stat_ff, drv_ff);
      snc_pkg::SRC_ID: fetch = (col_ff == 12'h000) ? MFR_ID :
        (col_ff == 12'h001) ? DEV_ID0 : (col_ff == 12'h002) ? DEV_ID1 : 8'h00;
      default: fetch = (col_ff > snc_pkg::COL_LAST) ? snc_pkg::OOB_BYTE : cache_mem[col_ff];
    endcase
    cur_byte = (out_cnt_ff == 3'h0) ? fetch : out_sr_ff;
  end

  // shifter: changes lanes on sclk fall only
  always_ff @(posedge clk)
  begin
    if (!reset_n || !cs_act)
    begin
      out_sr_ff <= 8'h00;
      out_cnt_ff <= 3'h0;
      col_ff <= 12'h000;
      sio_out_ff <= 4'h0;
      sio_oe_ff <= 4'h0;
    end
    else if (byte_done && ev_out)
    begin
      col_ff <= start_col;
      out_cnt_ff <= 3'h0;
      sio_oe_ff <= (lanes_out(op_ff) == snc_pkg::W4) ? 4'hF :
        (lanes_out(op_ff) == snc_pkg::W2) ? 4'h3 : 4'h2;
    end
    else if (sclk_fall && phase_ff == snc_pkg::PH_OUT)
    begin
      out_sr_ff <= cur_byte << w_out;
      out_cnt_ff <= out_cnt_ff + w_out;
      // column advances per byte, held one past the last page column
      if (out_cnt_ff == 3'h0 && src_ff != snc_pkg::SRC_FEAT && col_ff <= snc_pkg::COL_LAST)
        col_ff <= col_ff + 12'h001;
      case (w_out)
        snc_pkg::W4: sio_out_ff <= cur_byte[7:4];
        snc_pkg::W2: sio_out_ff <= {2'h0, cur_byte[7:6]};
        default: sio_out_ff <= {2'h0, cur_byte[7], 1'b0};
      endcase
    end
  end

  // cache fill from the array side
  always_ff @(posedge clk)
  begin
    if (cache_wr_en && cache_wr_addr <= snc_pkg::COL_LAST)
      cache_mem[cache_wr_addr] <= cache_wr_data;
  end

  // writable features; reset command leaves them alone
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      prot_ff <= snc_pkg::PROT_RESET;
      cfg_ff <= snc_pkg::CFG_RESET;
      cfg_ff[snc_pkg::OTP_PROTECT_BIT] <= otp_protect_nv;
      drv_ff <= snc_pkg::DRV_RESET;
    end
    else if (ev_setf)
    begin
      case (addr_sr_ff[7:0])
        snc_pkg::FA_PROT:
          if (!(prot_ff[snc_pkg::GUARD_BIT] && !wp_n))
            prot_ff <= nb & snc_pkg::WM_PROT;
        snc_pkg::FA_CFG:
        begin
          cfg_ff <= nb & snc_pkg::WM_CFG;
          // lock bit follows only its stored copy, a volatile write must not undo it
          cfg_ff[snc_pkg::OTP_PROTECT_BIT] <= cfg_ff[snc_pkg::OTP_PROTECT_BIT];
        end
        snc_pkg::FA_DRV: drv_ff <= nb & snc_pkg::WM_DRV;
        default: ; // status and unknown addresses read-only
      endcase
    end
  end

  // busy timer for array operations
  assign busy_done = stat_ff.operation_in_progress && busy_cnt_ff == 24'h000001;
  always_ff @(posedge clk)
  begin
    arr_start_ff <= 1'b0;
    if (!reset_n)
    begin
      busy_cnt_ff <= 24'h000000;
      busy_op_ff <= snc_pkg::AOP_READ;
      arr_op_ff <= snc_pkg::AOP_READ;
      arr_row_ff <= 24'h000000;
    end
    else if (ev_reset)
      busy_cnt_ff <= 24'h000000; // aborts a running operation
    else if (ev_start && (ev_op == snc_pkg::AOP_READ || stat_ff.write_enable_latch))
    begin
      arr_start_ff <= 1'b1;
      arr_op_ff <= ev_op;
      busy_op_ff <= ev_op;
      arr_row_ff <= nxt_addr;
      busy_cnt_ff <= (ev_op == snc_pkg::AOP_READ) ? 24'(snc_pkg::RD_CYCLES) :
        (ev_op == snc_pkg::AOP_PROG) ? 24'(PROG_CYCLES) : 24'(ERASE_CYCLES);
    end
    else if (busy_cnt_ff != 24'h000000)
      busy_cnt_ff <= busy_cnt_ff - 24'h000001;
  end

  // status: later assignments win, so sets beat clears
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      stat_ff <= '0;
    else
    begin
      if (busy_done)
      begin
        stat_ff.operation_in_progress <= 1'b0;
        if (busy_op_ff != snc_pkg::AOP_READ)
          stat_ff.write_enable_latch <= 1'b0;
        if (busy_op_ff == snc_pkg::AOP_READ)
          stat_ff.ecc <= arr_ecc;
        if (busy_op_ff == snc_pkg::AOP_PROG)
          stat_ff.p_fail <= arr_fail;
        if (busy_op_ff == snc_pkg::AOP_ERASE)
          stat_ff.e_fail <= arr_fail;
      end
      if (ev_write_disable_cmd)
        stat_ff.write_enable_latch <= 1'b0;
      if (ev_reset)
      begin
        stat_ff.write_enable_latch <= 1'b0;
        stat_ff.operation_in_progress <= 1'b0;
        if (!stat_ff.operation_in_progress)
        begin
          stat_ff.p_fail <= 1'b0;
          stat_ff.e_fail <= 1'b0;
          stat_ff.ecc <= 3'h0;
        end
      end
      if (ev_start && (ev_op == snc_pkg::AOP_READ || stat_ff.write_enable_latch))
        stat_ff.operation_in_progress <= 1'b1;
      if (ev_write_enable_cmd)
        stat_ff.write_enable_latch <= 1'b1;
    end
  end

  assign sio_out = sio_out_ff;
  assign sio_oe = sio_oe_ff;
  assign arr_start = arr_start_ff;
  assign arr_op = arr_op_ff;
  assign arr_row = arr_row_ff;

  AST_WRITE_ENABLE_CMD_SETS: assert property (@(posedge clk) disable iff (!reset_n)
    ev_write_enable_cmd |=> stat_ff.write_enable_latch) else $error("write latch not set");
  AST_WRITE_DISABLE_CMD_CLEARS: assert property (@(posedge clk) disable iff (!reset_n)
    ev_write_disable_cmd |=> !stat_ff.write_enable_latch) else $error("write latch not cleared");
  AST_RESET_WEL: assert property (@(posedge clk) disable iff (!reset_n)
    ev_reset |=> !stat_ff.write_enable_latch && !stat_ff.operation_in_progress) else $error("reset left latch or busy");
  AST_NO_WEL_NO_OP: assert property (@(posedge clk) disable iff (!reset_n)
    ev_start && ev_op != snc_pkg::AOP_READ && !stat_ff.write_enable_latch && !ev_reset
    |=> !arr_start_ff && $stable(stat_ff.operation_in_progress)) else $error("op ran without latch");
  AST_GUARD: assert property (@(posedge clk) disable iff (!reset_n)
    ev_setf && addr_sr_ff[7:0] == snc_pkg::FA_PROT && prot_ff[snc_pkg::GUARD_BIT] && !wp_n
    |=> $stable(prot_ff)) else $error("guarded protection changed");
  AST_QE_GATE: assert property (@(posedge clk) disable iff (!reset_n)
    byte_done && phase_ff == snc_pkg::PH_CMD && !qe &&
    (nb == snc_pkg::OP_RD_X4 || nb == snc_pkg::OP_RD_QUAD_IO)
    |=> phase_ff == snc_pkg::PH_IGNORE) else $error("quad accepted without enable");
  AST_READ_BUSY: assert property (@(posedge clk) disable iff (!reset_n)
    ev_start && ev_op == snc_pkg::AOP_READ && !ev_reset
    |=> arr_start_ff && stat_ff.operation_in_progress ##1 stat_ff.operation_in_progress [*7]) else $error("page read not busy");
  AST_OIP_DONE: assert property (@(posedge clk) disable iff (!reset_n)
    busy_done && !ev_start |=> !stat_ff.operation_in_progress) else $error("busy stuck after done");
  AST_OUT_OE: assert property (@(posedge clk) disable iff (!reset_n)
    byte_done && ev_out |=> sio_oe_ff != 4'h0) else $error("output not enabled");
  AST_OTP_KEEP: assert property (@(posedge clk) disable iff (!reset_n)
    ev_setf && addr_sr_ff[7:0] == snc_pkg::FA_CFG
    |=> $stable(cfg_ff[snc_pkg::OTP_PROTECT_BIT])) else $error("stored otp lock changed");
endmodule

// ### tb/snc_host.sv
/*
  host spi master model, mode 0, for the serial nand command block.
  assumes the bench calls its tasks; steps are paced by the 50 MHz clk.
*/
`timescale 1ns/1ps
module snc_host (
  input wire logic clk,
  output logic sclk,
  output logic cs_n,
  output logic [3:0] sio_in,
  input wire logic [3:0] sio_out,
  input wire logic [3:0] sio_oe
);
  logic [3:0] drv = 4'hA; // host lane values
  logic wp_n = 1'b1; // write protect level on lane 2
  // pad level: device lanes where enabled, else host
  assign sio_in = (sio_oe & sio_out) | (~sio_oe & drv);
  // link clock idles low between frames
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
  end
  // half of the 160 ns link period
  task automatic half();
    repeat (4) @(negedge clk);
  endtask
  task automatic open();
    half();
    cs_n = 1'b0;
    half();
  endtask
  // long gap, released lanes flip so stale data never reads back
  task automatic close();
    half();
    cs_n = 1'b1;
    drv = ~drv;
    half();
    half();
  endtask
  // data set while sclk low, taken by the device at the rise
  task automatic put(input logic [7:0] b, input int w);
    logic [7:0] s;
    s = b;
    for (int k = 0; k < 8 / w; k++)
    begin
      drv = {1'b1, wp_n, ~drv[1], s[7]};
      if (w == 2) drv[1:0] = s[7:6];
      if (w == 4) drv = s[7:4];
      s = s << w;
      half();
      sclk = 1'b1;
      half();
      sclk = 1'b0;
    end
  endtask
  // lanes read late in the high phase, clear of the sync delay
  task automatic get(output logic [7:0] b, input int w);
    b = 8'h00;
    for (int k = 0; k < 8 / w; k++)
    begin
      drv = ~drv;
      half();
      sclk = 1'b1;
      half();
      if (w == 1) b = {b[6:0], sio_in[1]};
      if (w == 2) b = {b[5:0], sio_in[1:0]};
      if (w == 4) b = {b[3:0], sio_in};
      sclk = 1'b0;
    end
  endtask
endmodule

// ### tb/snc_top_tb_top.sv
/*
  bench for the serial nand command block: feature, read, id and
  write latch traffic through the host model, judged byte by byte.
  assumes snc_host on the link and a 50 MHz clk.
*/
`timescale 1ns/1ps
`define CHK(nm, ex, got) chk(nm, ex, got)
module snc_top_tb_top;
  localparam logic [7:0] MFR = 8'h6D; // arbitrary value
  localparam logic [7:0] DV0 = 8'h2E; // arbitrary value
  localparam logic [7:0] DV1 = 8'h47; // arbitrary value
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic sclk;
  logic cs_n;
  logic [3:0] sio_in;
  logic [3:0] sio_out;
  logic [3:0] sio_oe;
  logic otp_protect_nv = 1'b1; // stored otp lock set
  logic cache_wr_en = 1'b0;
  logic [11:0] cache_wr_addr = 12'h000;
  logic [7:0] cache_wr_data = 8'h00;
  logic arr_fail = 1'b0;
  logic [2:0] arr_ecc = 3'h5;
  logic arr_start;
  logic [1:0] arr_op;
  logic [23:0] arr_row;
  logic [7:0] v; // last byte read
  int starts = 0; // array start pulses seen
  int num_errors = 0;
  int n_checks = 0;
  always #10 clk = ~clk;
  // count array start pulses, mid-cycle so clear of the launching edge
  always @(negedge clk)
  begin
    if (arr_start === 1'b1) starts++;
  end
  snc_top #(.MFR_ID(MFR), .DEV_ID0(DV0), .DEV_ID1(DV1), .PROG_CYCLES(20),
    .ERASE_CYCLES(20)) snc_top_i (.clk(clk), .reset_n(reset_n), .sclk(sclk),
    .cs_n(cs_n), .sio_in(sio_in), .sio_out(sio_out), .sio_oe(sio_oe),
    .otp_protect_nv(otp_protect_nv), .cache_wr_en(cache_wr_en), .cache_wr_addr(cache_wr_addr),
    .cache_wr_data(cache_wr_data), .arr_fail(arr_fail), .arr_ecc(arr_ecc),
    .arr_start(arr_start), .arr_op(arr_op), .arr_row(arr_row));
  snc_host snc_host_i (.clk(clk), .sclk(sclk), .cs_n(cs_n), .sio_in(sio_in),
    .sio_out(sio_out), .sio_oe(sio_oe));
  task automatic chk(input string nm, input logic [23:0] ex, input logic [23:0] got);
    n_checks++;
    if (got !== ex)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // cache content the bench loads, ff past the page end
  function automatic logic [7:0] cval(input logic [11:0] a);
    return (a > 12'h87F) ? 8'hFF : a[7:0] + 8'h30;
  endfunction
  // opcode with zero or three row bytes
  task automatic cmd(input logic [7:0] op, input int n, input logic [23:0] row);
    snc_host_i.open();
    snc_host_i.put(op, 1);
    for (int i = 2; i >= 3 - n; i--) snc_host_i.put(row[i*8 +: 8], 1);
    snc_host_i.close();
  endtask
  // reserved bits always sent as zero by the callers
  task automatic setf(input logic [7:0] a, input logic [7:0] d, input bit dum);
    snc_host_i.open();
    snc_host_i.put(8'h1F, 1);
    snc_host_i.put(a, 1);
    snc_host_i.put(d, 1);
    if (dum) snc_host_i.put(8'h00, 1);
    snc_host_i.close();
  endtask
  task automatic getf(input logic [7:0] a);
    snc_host_i.open();
    snc_host_i.put(8'h0F, 1);
    snc_host_i.put(a, 1);
    snc_host_i.get(v, 1);
    snc_host_i.close();
  endtask
  // poll status until idle, bounded
  task automatic wait_idle();
    v = 8'h01;
    for (int i = 0; i < 80 && v[0] !== 1'b0; i++) getf(8'hC0);
    if (v[0] !== 1'b0)
    begin
      num_errors++;
      stop_test();
    end
  endtask
  // cache read; a refused one must leave every lane undriven
  task automatic rd(input logic [7:0] op, input int aw, input int dw,
    input logic [11:0] col, input bit on);
    logic [7:0] d;
    snc_host_i.open();
    snc_host_i.put(op, 1);
    if (aw == 1) snc_host_i.put(8'h00, 1);
    snc_host_i.put({4'h0, col[11:8]}, aw);
    snc_host_i.put((op == 8'h03) ? {col[7:1], 1'b0} : col[7:0], aw);
    if (op != 8'h03) snc_host_i.put(8'h00, aw);
    for (int i = 0; i < 2; i++)
    begin
      snc_host_i.get(d, dw);
      if (on) `CHK("cache", cval(col + 12'(i)), d);
      `CHK("oe", on ? ((dw == 1) ? 4'h2 : (dw == 2) ? 4'h3 : 4'hF) : 4'h0, sio_oe);
    end
    snc_host_i.close();
  endtask
  task automatic t_wel();
    getf(8'hB0);
    `CHK("cfg", 8'h80, v);
    getf(8'hD0);
    `CHK("drv", 8'h00, v);
    cmd(8'h06, 0, 0);
    snc_host_i.open();
    snc_host_i.put(8'h0F, 1);
    snc_host_i.put(8'hC0, 1);
    snc_host_i.get(v, 1);
    `CHK("wel", 8'h02, v);
    snc_host_i.get(v, 1);
    `CHK("stream", 8'h02, v);
    snc_host_i.close();
    cmd(8'h04, 0, 0);
    getf(8'hC0);
    `CHK("write_disable_cmd", 8'h00, v);
    cmd(8'h06, 0, 0);
    cmd(8'hFF, 0, 0);
    getf(8'hC0);
    `CHK("rst", 8'h00, v);
  endtask
  task automatic t_feat();
    setf(8'hB0, 8'h01, 1'b1);
    getf(8'hB0);
    `CHK("cfg", 8'h81, v);
    setf(8'hC0, 8'h7E, 1'b0);
    getf(8'hC0);
    `CHK("stat", 8'h00, v);
    setf(8'hD0, 8'h60, 1'b0);
    cmd(8'hFF, 0, 0);
    getf(8'hD0);
    `CHK("drv", 8'h60, v);
    getf(8'hB0);
    `CHK("cfg", 8'h81, v);
  endtask
  task automatic t_read();
    logic [7:0] ops [6] = '{8'h03, 8'h0B, 8'h3B, 8'h6B, 8'hBB, 8'hEB};
    int aws [6] = '{1, 1, 1, 1, 2, 4};
    int dws [6] = '{1, 1, 2, 4, 2, 4};
    logic [11:0] ca [3] = '{12'h010, 12'h011, 12'h87F};
    cmd(8'h13, 3, 24'h012345);
    `CHK("start", 24'd1, 24'(starts));
    `CHK("row", 24'h012345, arr_row);
    getf(8'hC0);
    `CHK("busy", 1'b1, v[0]);
    wait_idle();
    `CHK("ecc", 8'h50, v);
    foreach (ca[i])
    begin
      @(negedge clk);
      cache_wr_en = 1'b1;
      cache_wr_addr = ca[i];
      cache_wr_data = cval(ca[i]);
    end
    @(negedge clk);
    cache_wr_en = 1'b0;
    for (int i = 0; i < 6; i++) rd(ops[i], aws[i], dws[i], 12'h010, 1'b1);
    rd(8'h0B, 1, 1, 12'h87F, 1'b1);
    cmd(8'hFF, 0, 0);
    getf(8'hC0);
    `CHK("idle rst", 8'h00, v);
  endtask
  task automatic t_guard();
    setf(8'hB0, 8'h00, 1'b0);
    getf(8'hB0);
    `CHK("otp", 8'h80, v);
    rd(8'h6B, 1, 4, 12'h010, 1'b0);
    rd(8'hEB, 4, 4, 12'h010, 1'b0);
    setf(8'hA0, 8'hB8, 1'b0);
    snc_host_i.wp_n = 1'b0;
    setf(8'hA0, 8'h00, 1'b0);
    getf(8'hA0);
    `CHK("guard", 8'hB8, v);
    snc_host_i.wp_n = 1'b1;
    setf(8'hA0, 8'h00, 1'b0);
    getf(8'hA0);
    `CHK("unguard", 8'h00, v);
  endtask
  task automatic t_prog();
    arr_fail = 1'b1;
    cmd(8'h10, 3, 24'h000040);
    `CHK("no wel", 24'd1, 24'(starts));
    cmd(8'h06, 0, 0);
    cmd(8'hD8, 3, 24'h000080);
    `CHK("erase", 24'd2, 24'(starts));
    `CHK("op", 2'h2, arr_op);
    wait_idle();
    `CHK("efail", 8'h04, v);
    cmd(8'hFF, 0, 0);
    getf(8'hC0);
    `CHK("clr", 8'h00, v);
    cmd(8'h06, 0, 0);
    cmd(8'h10, 3, 24'h000040);
    `CHK("prog", 24'h000003, 24'(starts));
    `CHK("pop", 2'h1, arr_op);
    wait_idle();
    `CHK("pfail", 8'h08, v);
    snc_host_i.open();
    snc_host_i.put(8'h9F, 1);
    snc_host_i.get(v, 1);
    `CHK("mfr", MFR, v);
    snc_host_i.get(v, 1);
    `CHK("dev0", DV0, v);
    snc_host_i.get(v, 1);
    `CHK("dev1", DV1, v);
    snc_host_i.close();
  endtask
  // reset, then each scenario in turn
  initial
  begin
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    t_wel();
    t_feat();
    t_read();
    t_guard();
    t_prog();
    stop_test();
  end
endmodule
